// ### msba_pkg.sv
//
// Contract
// - sixteen 16-bit columns, 8K or 4K deep
// - low row bits index, upper bits pick columns
// - short address shifted right, bit0 picks half
// - 48-bit access uses three columns, bits 13-15 at 8K deep, 12-14 at 4K
// - 32-bit access uses two columns, bits 13-15 at 8K deep, 12-14 at 4K
// - short access picks one column of pair
// - contiguous 32-bit start, 8K-deep variant
// - contiguous 32-bit start, 4K-deep variant
// - odd group count leaves noncontiguous region
// - gap addresses overwrite other width's cells
// - writes enter two-deep shadow buffer
// - new write commits older entry to array
// - reads of recent writes come from buffer
// - buffer match also requires the same 48/32 mapping class
// - width bit selects 32 or 48-bit data access
// - 32-bit block drops low 16, reads zeros
// - exchange register accesses 48-bit unless short
// - width bit applies to every requester except serial DMA
// - serial DMA data capped at 32 bits unless exchange, rounding ignored
// - short reads zero-filled or sign-extended
package msba_pkg;
  localparam logic [7:0] MSBA_CTRL       = 8'h00;
  localparam logic [7:0] MSBA_ADDR       = 8'h04;
  localparam logic [7:0] MSBA_WDATA_LO   = 8'h08;
  localparam logic [7:0] MSBA_WDATA_HI   = 8'h0c;
  localparam logic [7:0] MSBA_CMD        = 8'h10;
  localparam logic [7:0] MSBA_RDATA_LO   = 8'h14;
  localparam logic [7:0] MSBA_RDATA_HI   = 8'h18;
  localparam logic [7:0] MSBA_STATUS     = 8'h1c;
  localparam logic [7:0] MSBA_CALC_N     = 8'h20;
  localparam logic [7:0] MSBA_CALC_START = 8'h24;
  localparam int MSBA_CTRL_WSEL = 0;
  localparam int MSBA_CTRL_SSE  = 1;
  localparam int MSBA_CTRL_RND  = 2;
  localparam int MSBA_CMD_KIND  = 0;
  localparam int MSBA_CMD_EXCH  = 2;
  localparam int MSBA_CMD_REQ   = 3;
  localparam int MSBA_CMD_WR    = 5;
  localparam logic [2:0] MSBA_CTRL_RST = 3'h0;
  localparam int MSBA_COLS      = 16;
  localparam int MSBA_DEPTH_BIG = 8192;
  localparam int MSBA_DEPTH_SML = 4096;
  localparam int MSBA_W48_GRPS  = 5;
  localparam logic [4:0][2:0] MSBA_CONTIG_MUL = {3'h7, 3'h5, 3'h4, 3'h2, 3'h1};
  typedef enum logic [1:0] {
    MSBA_K_INSTR = 2'h0,
    MSBA_K_DATA  = 2'h1,
    MSBA_K_SHORT = 2'h2
  } msba_kind_e;
  typedef enum logic [1:0] {
    MSBA_W48 = 2'h0,
    MSBA_W32 = 2'h1,
    MSBA_W16 = 2'h2
  } msba_width_e;
  typedef enum logic [1:0] {
    MSBA_R_CORE  = 2'h0,
    MSBA_R_DMA   = 2'h1,
    MSBA_R_HOST  = 2'h2,
    MSBA_R_SPORT = 2'h3
  } msba_req_e;
  typedef struct packed {
    logic              valid;
    logic              w48;
    logic [15:0]       addr;
    logic [15:0]       mask;
    logic [15:0][15:0] cols;
  } msba_entry_s;
endpackage

// ### msba_block.sv
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module msba_block #(
  parameter int DEPTH = 8192
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  localparam int RB = $clog2(DEPTH);

  generate
    if (DEPTH != msba_pkg::MSBA_DEPTH_BIG && DEPTH != msba_pkg::MSBA_DEPTH_SML)
    begin : g_bad_depth
      $error("msba_block: DEPTH must be 8192 or 4096");
    end
  endgenerate

  // ****************************************
  // register bus decode
  // ****************************************
  logic [7:0]             off;
  logic                   mapped;
  logic                   wr_acc;
  logic                   cmd_go;
  logic                   wr_go;
  logic                   rd_go;
  msba_pkg::msba_kind_e   kind;
  msba_pkg::msba_req_e    req;
  logic                   exch;
  logic [2:0]             ctrl;
  logic [15:0]            addr_q;
  logic [47:0]            wdata_q;
  logic [47:0]            rdata_q;
  logic [15:0]            calc_n;
  logic                   st_hit;
  msba_pkg::msba_entry_s  sh [2];

  assign off    = paddr[7:0];
  assign mapped = (paddr[31:8] == 24'h0) && (off[1:0] == 2'h0)
                  && (off <= msba_pkg::MSBA_CALC_START);
  assign wr_acc = psel && penable && pwrite && mapped;
  assign cmd_go = wr_acc && (off == msba_pkg::MSBA_CMD);
  assign wr_go  = cmd_go && pwdata[msba_pkg::MSBA_CMD_WR];
  assign rd_go  = cmd_go && !pwdata[msba_pkg::MSBA_CMD_WR];
  assign kind   = msba_pkg::msba_kind_e'(pwdata[msba_pkg::MSBA_CMD_KIND +: 2]);
  assign req    = msba_pkg::msba_req_e'(pwdata[msba_pkg::MSBA_CMD_REQ +: 2]);
  assign exch   = pwdata[msba_pkg::MSBA_CMD_EXCH];
  assign pready = 1'b1;

  // ****************************************
  // access width resolution
  // ****************************************
  msba_pkg::msba_width_e eff_w;
  logic                  wsel;
  logic                  short_sign_extend_bit;

  assign wsel = ctrl[msba_pkg::MSBA_CTRL_WSEL];
  assign short_sign_extend_bit  = ctrl[msba_pkg::MSBA_CTRL_SSE];

  // rounding-precision bit is stored only; it never steers width
  // short wins over the exchange target: exchange short reads stay
  // 16-bit and are zero-filled, every other exchange access is 48-bit
  always_comb
  begin
    if (kind == msba_pkg::MSBA_K_SHORT)
      eff_w = msba_pkg::MSBA_W16;
    else if (kind == msba_pkg::MSBA_K_INSTR || exch)
      eff_w = msba_pkg::MSBA_W48;
    else if (wsel && req != msba_pkg::MSBA_R_SPORT)
      eff_w = msba_pkg::MSBA_W48;
    else
      eff_w = msba_pkg::MSBA_W32;
  end

  // ****************************************
  // address mapping
  // ****************************************
  logic [15:0]       na;
  logic [RB-1:0]     row;
  logic [2:0]        grp;
  logic              hb;
  logic [15:0]       mask;
  logic [15:0][15:0] ncol;

  assign na  = (eff_w == msba_pkg::MSBA_W16) ? {1'b0, addr_q[15:1]} : addr_q;
  assign hb  = addr_q[0];
  assign row = na[RB-1:0];
  // with 4096-deep columns the group field sits one bit lower
  assign grp = na[RB+2:RB];

  // no validity check: gap addresses land on the other width's cells
  always_comb
  begin
    mask = '0;
    ncol = '0;
    for (int c = 0; c < msba_pkg::MSBA_COLS; c++)
    begin
      case (eff_w)
        msba_pkg::MSBA_W48:
        begin
          if (c >= 3 * int'(grp) && c < 3 * int'(grp) + 3)
          begin
            mask[c] = 1'b1;
            ncol[c] = wdata_q[16 * (c - 3 * int'(grp)) +: 16];
          end
        end
        msba_pkg::MSBA_W32:
        begin
          if (c / 2 == int'(grp))
          begin
            mask[c] = 1'b1;
            ncol[c] = (c % 2 == 1) ? wdata_q[47:32] : wdata_q[31:16];
          end
        end
        msba_pkg::MSBA_W16:
        begin
          if (c == 2 * int'(grp) + int'(hb))
          begin
            mask[c] = 1'b1;
            ncol[c] = wdata_q[31:16];
          end
        end
        default:
        begin
          mask[c] = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // array and shadow write buffer
  // ****************************************
  localparam int MSBA_MEM_WORDS = msba_pkg::MSBA_COLS * DEPTH;
  // cells indexed {column, row}
  logic [15:0]       mem [MSBA_MEM_WORDS];
  logic              fwd0;
  logic              fwd1;
  logic              hit;
  logic [15:0][15:0] cv;
  logic [47:0]       rd;

  // match on address and mapping class only, never on physical cells
  assign fwd0 = sh[0].valid && sh[0].addr == na
                && sh[0].w48 == (eff_w == msba_pkg::MSBA_W48);
  assign fwd1 = sh[1].valid && sh[1].addr == na
                && sh[1].w48 == (eff_w == msba_pkg::MSBA_W48);
  // st_hit reports whether any column came from the buffer
  assign hit  = (fwd0 && |(sh[0].mask & mask)) || (fwd1 && |(sh[1].mask & mask));

  always_comb
  begin
    for (int c = 0; c < msba_pkg::MSBA_COLS; c++)
    begin
      cv[c] = mem[{4'(c), row}];
      if (fwd1 && sh[1].mask[c])
        cv[c] = sh[1].cols[c];
      if (fwd0 && sh[0].mask[c])
        cv[c] = sh[0].cols[c];
    end
  end

  always_comb
  begin
    rd = '0;
    case (eff_w)
      msba_pkg::MSBA_W48:
      begin
        for (int j = 0; j < 3; j++)
        begin
          if (3 * int'(grp) + j < msba_pkg::MSBA_COLS)
            rd[16 * j +: 16] = cv[3 * int'(grp) + j];
        end
      end
      msba_pkg::MSBA_W32:
      begin
        rd[47:16] = {cv[{grp, 1'b1}], cv[{grp, 1'b0}]};
      end
      msba_pkg::MSBA_W16:
      begin
        // exchange register never sees sign extension
        rd[47:32] = (short_sign_extend_bit && !exch) ? {16{cv[{grp, hb}][15]}} : 16'h0;
        rd[31:16] = cv[{grp, hb}];
      end
      default:
      begin
        rd = '0;
      end
    endcase
  end

  // array cells have no reset; the buffer state and the registers do
  always_ff @(posedge pclk)
  begin
    for (int c = 0; c < msba_pkg::MSBA_COLS; c++)
    begin
      if (wr_go && sh[1].valid && sh[1].mask[c])
        mem[{4'(c), sh[1].addr[RB-1:0]}] <= sh[1].cols[c];
    end
  end

  // the oldest entry drains only when a new write arrives;
  // a read never moves the buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh[0] <= '0;
      sh[1] <= '0;
    end
    else if (wr_go)
    begin
      sh[1] <= sh[0];
      sh[0] <= {1'b1, eff_w == msba_pkg::MSBA_W48, na, mask, ncol};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= '0;
      st_hit  <= 1'b0;
    end
    else if (rd_go)
    begin
      rdata_q <= rd;
      st_hit  <= hit;
    end
  end

  // ****************************************
  // layout helper: contiguous data start
  // ****************************************
  logic [15:0] nm1;
  logic [2:0]  kq;
  logic [16:0] calc_start;
  logic        noncontig;

  assign nm1 = calc_n - 16'h1;
  assign kq  = 3'(nm1 >> RB);
  always_comb
  begin
    calc_start = 17'h0;
    if (int'(kq) < msba_pkg::MSBA_W48_GRPS)
      calc_start = 17'(int'(msba_pkg::MSBA_CONTIG_MUL[kq]) * DEPTH
                   + int'(nm1 & 16'(DEPTH - 1)) + 1);
  end
  // k above four: the 48-bit area covers the whole block
  assign noncontig = !kq[0];

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl    <= msba_pkg::MSBA_CTRL_RST;
      addr_q  <= '0;
      wdata_q <= '0;
      calc_n  <= '0;
    end
    else if (wr_acc)
    begin
      // cmd writes launch accesses only; nothing is stored for them
      case (off)
        msba_pkg::MSBA_CTRL:     ctrl <= pwdata[2:0];
        msba_pkg::MSBA_ADDR:     addr_q <= pwdata[15:0];
        msba_pkg::MSBA_WDATA_LO: wdata_q[31:0] <= pwdata;
        msba_pkg::MSBA_WDATA_HI: wdata_q[47:32] <= pwdata[15:0];
        msba_pkg::MSBA_CALC_N:   calc_n <= pwdata[15:0];
        default:                 calc_n <= calc_n;
      endcase
    end
  end

  // read data latched in the setup phase, so it stands through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= !mapped;
      case (mapped ? off : 8'hff)
        msba_pkg::MSBA_CTRL:       prdata <= {29'h0, ctrl};
        msba_pkg::MSBA_ADDR:       prdata <= {16'h0, addr_q};
        msba_pkg::MSBA_WDATA_LO:   prdata <= wdata_q[31:0];
        msba_pkg::MSBA_WDATA_HI:   prdata <= {16'h0, wdata_q[47:32]};
        msba_pkg::MSBA_RDATA_LO:   prdata <= rdata_q[31:0];
        msba_pkg::MSBA_RDATA_HI:   prdata <= {16'h0, rdata_q[47:32]};
        msba_pkg::MSBA_STATUS:     prdata <= {29'h0, st_hit, sh[1].valid, sh[0].valid};
        msba_pkg::MSBA_CALC_N:     prdata <= {16'h0, calc_n};
        msba_pkg::MSBA_CALC_START: prdata <= {noncontig, 14'h0, calc_start};
        default:                   prdata <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_buf_order: assert property (!sh[0].valid |-> !sh[1].valid)
    else $error("older buffer entry valid without newer");
  a_buf_shift: assert property (wr_go && sh[0].valid
    |=> sh[1].valid && sh[0].valid)
    else $error("two writes did not fill buffer");
  a_buf_commit: assert property (wr_go |=> sh[1] == $past(sh[0]))
    else $error("older entry not pushed on write");
  a_read_keeps: assert property (rd_go |=> $stable(sh[0]) && $stable(sh[1]))
    else $error("read disturbed the buffer");
  a_mask_w48: assert property (cmd_go && eff_w == msba_pkg::MSBA_W48 && grp < 3'h5
    |-> mask == (16'h7 << (3 * int'(grp))))
    else $error("48-bit column group wrong");
  a_mask_w32: assert property (cmd_go && eff_w == msba_pkg::MSBA_W32
    |-> mask == (16'h3 << (2 * int'(grp))))
    else $error("32-bit column pair wrong");
  a_mask_w16: assert property (cmd_go && eff_w == msba_pkg::MSBA_W16
    |-> $countones(mask) == 1 && mask[{grp, hb}])
    else $error("short column select wrong");
  a_short_row: assert property (cmd_go && eff_w == msba_pkg::MSBA_W16
    |-> row == addr_q[RB:1])
    else $error("short address not shifted");
  a_fwd_w32: assert property (rd_go && eff_w == msba_pkg::MSBA_W32 && fwd0
    && sh[0].mask == mask |=> st_hit
    && rdata_q[47:16] == {$past(sh[0].cols[{grp, 1'b1}]), $past(sh[0].cols[{grp, 1'b0}])})
    else $error("recent write not forwarded");
  a_no_cross: assert property (rd_go && eff_w != msba_pkg::MSBA_W48 && sh[0].w48
    |-> !fwd0)
    else $error("48-bit entry forwarded to narrow read");
  a_trunc_lo: assert property (rd_go && kind == msba_pkg::MSBA_K_DATA && !exch && !wsel
    |=> rdata_q[15:0] == 16'h0)
    else $error("32-bit block read low bits not zero");
  a_width_sel: assert property (cmd_go && kind == msba_pkg::MSBA_K_DATA && !exch && wsel
    && req != msba_pkg::MSBA_R_SPORT |-> eff_w == msba_pkg::MSBA_W48)
    else $error("data access ignores width bit");
  a_exch_w48: assert property (cmd_go && exch && kind != msba_pkg::MSBA_K_SHORT
    |-> eff_w == msba_pkg::MSBA_W48)
    else $error("exchange access not 48-bit");
  a_sport_cap: assert property (cmd_go && req == msba_pkg::MSBA_R_SPORT
    && kind == msba_pkg::MSBA_K_DATA && !exch |-> eff_w == msba_pkg::MSBA_W32)
    else $error("serial DMA above 32 bits");
  a_zero_fill: assert property (rd_go && eff_w == msba_pkg::MSBA_W16 && exch
    |=> rdata_q[47:32] == 16'h0)
    else $error("exchange short read extended");
  a_sign_ext: assert property (rd_go && eff_w == msba_pkg::MSBA_W16 && short_sign_extend_bit && !exch
    |=> rdata_q[47:32] == {16{rdata_q[31]}})
    else $error("short read not sign-extended");
  a_calc_cap: assert property (kq > 3'h4 |-> calc_start == 17'h0)
    else $error("start given beyond five groups");
  a_bad_addr: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  c_w48_write: cover property (wr_go && eff_w == msba_pkg::MSBA_W48);
  c_fwd_read: cover property (rd_go && hit);
  c_sext_read: cover property (rd_go && eff_w == msba_pkg::MSBA_W16 && short_sign_extend_bit && !exch);
  c_commit: cover property (wr_go && sh[1].valid);
  c_exch_short: cover property (rd_go && eff_w == msba_pkg::MSBA_W16 && exch);
endmodule

// ### msba_req_model.sv
`timescale 1ns/1ps
// ****************************************
// requester standing on the far side of the bus
// ****************************************
module msba_req_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [31:0] ad,
  input  wire logic [31:0] wd,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  output logic             done,
  output logic      [31:0] rdata,
  output logic             err
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 32'h0;
      pwdata  <= 32'h0;
      done    <= 1'b0;
      rdata   <= 32'h0;
      err     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (psel && penable && pready)
      begin
        psel    <= 1'b0;
        penable <= 1'b0;
        rdata   <= prdata;
        err     <= pslverr;
        done    <= 1'b1;
        // released lines must not keep looking valid
        paddr   <= ~paddr;
        pwdata  <= ~pwdata;
      end
      else if (psel)
        penable <= 1'b1;
      else if (go)
      begin
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= ad;
        pwdata <= wd;
      end
    end
  end
endmodule

// ### msba_block_tb.sv
`timescale 1ns/1ps
module msba_block_tb;
  typedef struct packed {
    logic        w;
    logic [2:0]  ctrl;
    logic [15:0] addr;
    logic [5:0]  op;
    logic [15:0] hi;
    logic [31:0] lo;
    logic [15:0] ehi;
    logic [31:0] elo;
  } msba_row_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        go = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] ad = 32'h0;
  logic [31:0] wd = 32'h0;
  logic        psel, penable, pwrite, pready, pslverr, done, err;
  logic [31:0] paddr, pwdata, prdata, rdata;
  int          n_fail = 0;
  int          compares = 0;
  int          ns [6] = '{1, 8193, 16384, 16385, 40960, 40961};
  logic [31:0] st [6] = '{32'h80002001, 32'h4001, 32'h6000, 32'h80008001, 32'h80010000, 32'h0};
  msba_row_s   rows [11] = '{
    '{1'b1, 3'h0, 16'h0005, 6'h00, 16'h1234, 32'h89abcdef, 16'h1234, 32'h89abcdef},
    '{1'b1, 3'h0, 16'h6005, 6'h01, 16'h5566, 32'h778899aa, 16'h5566, 32'h77880000},
    '{1'b1, 3'h1, 16'h2010, 6'h01, 16'h0102, 32'h03040506, 16'h0102, 32'h03040506},
    '{1'b1, 3'h5, 16'h6100, 6'h19, 16'haaaa, 32'hbbbbcccc, 16'haaaa, 32'hbbbb0000},
    '{1'b1, 3'h1, 16'h4020, 6'h11, 16'h0a0b, 32'h0c0d0e0f, 16'h0a0b, 32'h0c0d0e0f},
    '{1'b1, 3'h0, 16'h4030, 6'h09, 16'h1111, 32'h22223333, 16'h1111, 32'h22220000},
    '{1'b1, 3'h0, 16'h4040, 6'h05, 16'h4444, 32'h55556666, 16'h4444, 32'h55556666},
    '{1'b1, 3'h2, 16'h800b, 6'h02, 16'h0000, 32'h9abc0000, 16'hffff, 32'h9abc0000},
    '{1'b1, 3'h2, 16'h800b, 6'h06, 16'h0000, 32'h9abc0000, 16'h0000, 32'h9abc0000},
    '{1'b0, 3'h0, 16'hc00b, 6'h02, 16'h0000, 32'h0, 16'h0000, 32'h55660000},
    '{1'b0, 3'h0, 16'hc00a, 6'h02, 16'h0000, 32'h0, 16'h0000, 32'h77880000}};

  always #5 pclk = ~pclk;

  msba_block #(.DEPTH(8192)) msba_block_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  msba_req_model msba_req_model_i (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .ad(ad),
    .wd(wd), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .done(done),
    .rdata(rdata), .err(err));

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    go <= 1'b1;
    wr <= w;
    ad <= {24'h0, a};
    wd <= d;
    @(posedge pclk);
    go <= 1'b0;
    for (t = 0; t < 50 && done !== 1'b1; t++)
      @(negedge pclk);
    if (t >= 50)
      chk("bus answer", 32'h1, 32'h0);
  endtask

  task automatic cmd(input logic [15:0] a, input logic [5:0] op, input logic [15:0] h,
                     input logic [31:0] l);
    apb(1'b1, msba_pkg::MSBA_ADDR, {16'h0, a});
    apb(1'b1, msba_pkg::MSBA_WDATA_LO, l);
    apb(1'b1, msba_pkg::MSBA_WDATA_HI, {16'h0, h});
    apb(1'b1, msba_pkg::MSBA_CMD, {26'h0, op});
  endtask

  task automatic get(input logic [15:0] eh, input logic [31:0] el);
    apb(1'b0, msba_pkg::MSBA_RDATA_LO, 32'h0);
    chk("rdata lo", el, rdata);
    apb(1'b0, msba_pkg::MSBA_RDATA_HI, 32'h0);
    chk("rdata hi", {16'h0, eh}, rdata);
  endtask

  task automatic status(input logic [31:0] e);
    apb(1'b0, msba_pkg::MSBA_STATUS, 32'h0);
    chk("status", e, rdata);
  endtask

  task conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude;
  end

  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(1'b1, msba_pkg::MSBA_CTRL, {29'h0, rows[i].ctrl});
      if (rows[i].w)
        cmd(rows[i].addr, rows[i].op | 6'h20, rows[i].hi, rows[i].lo);
      cmd(rows[i].addr, rows[i].op, 16'h0, 32'h0);
      get(rows[i].ehi, rows[i].elo);
    end
    // wide write over narrow cells, narrow read must miss the buffer
    apb(1'b1, msba_pkg::MSBA_CTRL, 32'h0);
    cmd(16'h0007, 6'h21, 16'hcafe, 32'hbeef1357);
    cmd(16'h6100, 6'h21, 16'h0, 32'h0);
    cmd(16'h6100, 6'h21, 16'h0, 32'h0);
    cmd(16'h0007, 6'h20, 16'h0a1b, 32'h2c3d4e5f);
    cmd(16'h0007, 6'h01, 16'h0, 32'h0);
    get(16'hcafe, 32'hbeef0000);
    status(32'h3);
    cmd(16'h6100, 6'h21, 16'h0, 32'h0);
    cmd(16'h6100, 6'h21, 16'h0, 32'h0);
    cmd(16'h0007, 6'h01, 16'h0, 32'h0);
    get(16'h2c3d, 32'h4e5f0000);
    apb(1'b0, 8'h28, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdata);
    foreach (ns[i])
    begin
      apb(1'b1, msba_pkg::MSBA_CALC_N, ns[i]);
      apb(1'b0, msba_pkg::MSBA_CALC_START, 32'h0);
      chk("contig start", st[i], rdata);
    end
    // second reset in mid-run empties the buffer
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    status(32'h0);
    apb(1'b0, msba_pkg::MSBA_CTRL, 32'h0);
    chk("ctrl reset", {29'h0, msba_pkg::MSBA_CTRL_RST}, rdata);
    cmd(16'h6100, 6'h01, 16'h0, 32'h0);
    status(32'h0);
    cmd(16'h6100, 6'h21, 16'h1357, 32'h24680000);
    status(32'h1);
    cmd(16'h6101, 6'h21, 16'h8642, 32'h97530000);
    status(32'h3);
    cmd(16'h6101, 6'h01, 16'h0, 32'h0);
    status(32'h7);
    get(16'h8642, 32'h97530000);
    conclude;
  end
endmodule
